// file: hdl/adcc_pin_decode.v
`timescale 1ns/10ps
`default_nettype none

module adcc_pin_decode #(
    parameter PKG_PINS = 100
) (
    input wire [3:0] pin_analog_config_i,
    output wire [15:0] analog_mask_o,
    output wire [15:0] present_mask_o
);

    genvar i;

    // Per input: analog or digital, and whether the package bonds it out
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_pin
            // Code k makes inputs 15-k..15 digital; zero keeps all analog
            assign analog_mask_o[i] = (pin_analog_config_i == 4'h0) ||
                                      (i < 15 - pin_analog_config_i);
            // Input 5 only in largest, 12..15 only in the two larger
            assign present_mask_o[i] = (i == 5) ? (PKG_PINS >= 100) :
                                       (i >= 12) ? (PKG_PINS >= 80) : 1'b1;
        end
    endgenerate

endmodule

`default_nettype wire

// file: hdl/adcc_sar.v
`timescale 1ns/10ps
`default_nettype none

module adcc_sar #(
    parameter BITS = 10
) (
    input wire clk_i,
    input wire rst_i,
    input wire abort_i,
    input wire start_i,
    input wire tick_i,
    input wire comp_i,
    output reg [BITS-1:0] dac_o,
    output reg [BITS-1:0] result_o,
    output reg done_o
);

    reg [BITS-1:0] trial;
    reg active;

    // Successive approximation, one bit per converter clock
    always @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            dac_o <= {BITS{1'b0}};
            trial <= {BITS{1'b0}};
            active <= 1'b0;
            done_o <= 1'b0;
            result_o <= {BITS{1'b0}};
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                trial <= {1'b1, {(BITS-1){1'b0}}};
                dac_o <= {1'b1, {(BITS-1){1'b0}}};
                active <= 1'b1;
            end else if (active && tick_i) begin
                // Drop the trial bit when input lies below the DAC level
                if (!trial[0]) begin
                    dac_o <= (comp_i ? dac_o : (dac_o & ~trial)) | (trial >> 1);
                    trial <= trial >> 1;
                end else begin
                    result_o <= comp_i ? dac_o : (dac_o & ~trial);
                    done_o <= 1'b1;
                    active <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: hdl/adcc_top.v
// Behaviour
// - Bits 5..2 pick analog input to convert
// - Bit 0 enables or disables the converter
// - Bit 1 reads busy while conversion runs
// - Bit 7 requests calibration on next conversion
// - Unimplemented bits read zero, ignore writes
// - Bit 5 picks negative reference source
// - Bit 4 picks positive reference source
// - Port code sets top inputs to digital
// - Absent channel conversions return arbitrary data
// - Input count follows package size
// - Inputs 5 and 12..15 package dependent
// - Each conversion gives a ten-bit result
// - Inputs 0,1 stay usable as LEDs
// - Five converter registers: results plus controls
// - Completion loads result, clears busy, flags
// - Busy flag starts conversion after acquisition
// - Reset clears controls, aborts, keeps result
`include "adcc_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module adcc_top #(
    parameter PKG_PINS = 100,
    parameter RES_BITS = 10,
    parameter CAL_TADS = `ADCC_CAL_TAD
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire comp_i,
    input wire [1:0] led_i,
    output reg [3:0] channel_select_o,
    output reg neg_ref_select_o,
    output reg pos_ref_select_o,
    output reg [15:0] analog_pins_o,
    output reg sample_o,
    output reg calibrate_o,
    output wire [RES_BITS-1:0] dac_o,
    output reg [1:0] led_o,
    output reg irq_o
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ACQ = 3'h1;
    localparam ST_CAL = 3'h2;
    localparam ST_CONV = 3'h3;
    localparam ST_GAP = 3'h4;
    localparam integer FRC_DIV = `ADCC_FRC_CYC;

    // Acquisition length in converter clocks
    function [4:0] acq_tads;
        input [2:0] code;
        begin
            case (code)
                3'h0: acq_tads = 5'h00;
                3'h1: acq_tads = 5'h02;
                3'h2: acq_tads = 5'h04;
                3'h3: acq_tads = 5'h06;
                3'h4: acq_tads = 5'h08;
                3'h5: acq_tads = 5'h0C;
                3'h6: acq_tads = 5'h10;
                default: acq_tads = 5'h14;
            endcase
        end
    endfunction

    // System clocks per converter clock
    function [7:0] tad_div;
        input [2:0] code;
        begin
            case (code)
                3'h0: tad_div = 8'h02;
                3'h1: tad_div = 8'h08;
                3'h2: tad_div = 8'h20;
                3'h4: tad_div = 8'h04;
                3'h5: tad_div = 8'h10;
                3'h6: tad_div = 8'h40;
                default: tad_div = FRC_DIV[7:0]; // Free-running clock, cut to counter width
            endcase
        end
    endfunction

    // Register state
    reg calibrate_next;
    reg [3:0] channel_select;
    reg conv_busy;
    reg converter_on;
    reg neg_ref_select;
    reg pos_ref_select;
    reg [3:0] pin_analog_config;
    reg result_right;
    reg [2:0] acq_sel;
    reg [2:0] clk_sel;
    reg [RES_BITS-1:0] result;
    reg [1:0] irq_stat;
    reg [1:0] irq_en;

    // Sequencer state
    reg [2:0] state;
    reg [4:0] phase;
    reg [7:0] tad_cnt;
    reg sar_start;
    reg done_evt;
    reg cal_evt;

    wire [15:0] analog_mask;
    wire [15:0] present_mask;
    wire [RES_BITS-1:0] sar_result;
    wire sar_done;
    wire tad_tick;
    wire abort;
    wire bus_req;
    wire wr_en;
    wire go_write;
    wire [1:0] irq_set;
    wire [1:0] irq_clr;
    wire [7:0] ctrl0_rd;
    wire [7:0] ctrl1_rd;
    wire [7:0] ctrl2_rd;
    wire [7:0] resh_rd;
    wire [7:0] resl_rd;

    adcc_pin_decode #(
        .PKG_PINS(PKG_PINS)
    ) u_decode (
        .pin_analog_config_i(pin_analog_config),
        .analog_mask_o(analog_mask),
        .present_mask_o(present_mask)
    );

    adcc_sar #(
        .BITS(RES_BITS)
    ) u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .abort_i(abort),
        .start_i(sar_start),
        .tick_i(tad_tick),
        .comp_i(comp_i),
        .dac_o(dac_o),
        .result_o(sar_result),
        .done_o(sar_done)
    );

    // Bus decode: writes land on the edge that samples ack
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_en = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign go_write = wr_en && (wb_adr_i == `ADCC_OFF_CTRL0) &&
                      wb_dat_i[`ADCC_C0_GO] && wb_dat_i[`ADCC_C0_ON];
    // Disabling the module drops any conversion
    assign abort = !converter_on;
    assign tad_tick = (state != ST_IDLE) && (tad_cnt == 8'h00);

    // Readback, unimplemented bits forced low
    assign ctrl0_rd = {calibrate_next, 1'b0, channel_select,
                       conv_busy && converter_on, converter_on};
    assign ctrl1_rd = {2'b00, neg_ref_select, pos_ref_select,
                       pin_analog_config};
    assign ctrl2_rd = {result_right, 1'b0, acq_sel, clk_sel};
    // Justification applied on read
    assign resh_rd = result_right ? {6'h00, result[9:8]} : result[9:2];
    assign resl_rd = result_right ? result[7:0] : {result[1:0], 6'h00};

    // Wishbone ack and read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                case (wb_adr_i)
                    `ADCC_OFF_CTRL0: wb_dat_o <= {24'h000000, ctrl0_rd};
                    `ADCC_OFF_CTRL1: wb_dat_o <= {24'h000000, ctrl1_rd};
                    `ADCC_OFF_CTRL2: wb_dat_o <= {24'h000000, ctrl2_rd};
                    `ADCC_OFF_RESH: wb_dat_o <= {24'h000000, resh_rd};
                    `ADCC_OFF_RESL: wb_dat_o <= {24'h000000, resl_rd};
                    `ADCC_OFF_ISTAT: wb_dat_o <= {30'h00000000, irq_stat};
                    `ADCC_OFF_IEN: wb_dat_o <= {30'h00000000, irq_en};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Software-written control fields
    always @(posedge clk_i) begin
        if (rst_i) begin
            calibrate_next <= 1'b0;
            channel_select <= 4'h0;
            converter_on <= 1'b0;
            neg_ref_select <= 1'b0;
            pos_ref_select <= 1'b0;
            pin_analog_config <= 4'h0;
            result_right <= 1'b0;
            acq_sel <= 3'h0;
            clk_sel <= 3'h0;
            irq_en <= 2'h0;
        end else if (wr_en) begin
            case (wb_adr_i)
                `ADCC_OFF_CTRL0: begin
                    calibrate_next <= wb_dat_i[`ADCC_C0_CAL];
                    channel_select <= wb_dat_i[`ADCC_C0_CHS_HI:`ADCC_C0_CHS_LO];
                    converter_on <= wb_dat_i[`ADCC_C0_ON];
                end
                `ADCC_OFF_CTRL1: begin
                    neg_ref_select <= wb_dat_i[`ADCC_C1_NREF];
                    pos_ref_select <= wb_dat_i[`ADCC_C1_PREF];
                    pin_analog_config <= wb_dat_i[`ADCC_C1_PCFG_HI:`ADCC_C1_PCFG_LO];
                end
                `ADCC_OFF_CTRL2: begin
                    result_right <= wb_dat_i[`ADCC_C2_FMT];
                    acq_sel <= wb_dat_i[`ADCC_C2_ACQ_HI:`ADCC_C2_ACQ_LO];
                    clk_sel <= wb_dat_i[`ADCC_C2_CS_HI:`ADCC_C2_CS_LO];
                end
                `ADCC_OFF_IEN: irq_en <= wb_dat_i[1:0];
                default: irq_en <= irq_en;
            endcase
        end
    end

    // Busy flag: set by software when enabled, cleared at completion
    always @(posedge clk_i) begin
        if (rst_i || abort) begin
            conv_busy <= 1'b0;
        end else if (go_write) begin
            conv_busy <= 1'b1;
        end else if (sar_done) begin
            conv_busy <= 1'b0;
        end
    end

    // Result holds across reset; unknown until first conversion
    always @(posedge clk_i) begin
        if (sar_done && !abort) begin
            // Absent channel gives whatever the comparator settled to
            result <= sar_result;
        end
    end

    // Converter clock divider, restarted on each request
    always @(posedge clk_i) begin
        if (rst_i || abort || state == ST_IDLE) begin
            tad_cnt <= tad_div(clk_sel) - 8'h01;
        end else if (tad_cnt == 8'h00) begin
            tad_cnt <= tad_div(clk_sel) - 8'h01;
        end else begin
            tad_cnt <= tad_cnt - 8'h01;
        end
    end

    // Sequencer: acquire, calibrate, convert, then mandatory gap
    always @(posedge clk_i) begin
        if (rst_i || abort) begin
            state <= ST_IDLE;
            phase <= 5'h00;
            sar_start <= 1'b0;
            done_evt <= 1'b0;
            cal_evt <= 1'b0;
        end else begin
            sar_start <= 1'b0;
            done_evt <= 1'b0;
            cal_evt <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (conv_busy) begin
                        if (acq_sel != 3'h0) begin
                            state <= ST_ACQ;
                            phase <= acq_tads(acq_sel);
                        end else if (calibrate_next) begin
                            state <= ST_CAL;
                            phase <= CAL_TADS[4:0];
                        end else begin
                            state <= ST_CONV;
                            sar_start <= 1'b1;
                        end
                    end
                end
                ST_ACQ: begin
                    if (tad_tick) begin
                        if (phase != 5'h01) begin
                            phase <= phase - 5'h01;
                        end else if (calibrate_next) begin
                            state <= ST_CAL;
                            phase <= CAL_TADS[4:0];
                        end else begin
                            state <= ST_CONV;
                            sar_start <= 1'b1;
                        end
                    end
                end
                ST_CAL: begin
                    if (tad_tick) begin
                        if (phase != 5'h01) begin
                            phase <= phase - 5'h01;
                        end else begin
                            state <= ST_CONV;
                            sar_start <= 1'b1;
                            cal_evt <= 1'b1;
                        end
                    end
                end
                ST_CONV: begin
                    if (sar_done) begin
                        state <= ST_GAP;
                        phase <= `ADCC_WAIT_TAD;
                        done_evt <= 1'b1;
                    end
                end
                ST_GAP: begin
                    if (tad_tick) begin
                        if (phase != 5'h01) begin
                            phase <= phase - 5'h01;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Sticky interrupt status, set wins over clear
    assign irq_set = {cal_evt, done_evt};
    assign irq_clr = (wr_en && wb_adr_i == `ADCC_OFF_ICLR) ? wb_dat_i[1:0] : 2'h0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
        end
    end

    // Registered drive of the analog front end
    always @(posedge clk_i) begin
        if (rst_i) begin
            channel_select_o <= 4'h0;
            neg_ref_select_o <= 1'b0;
            pos_ref_select_o <= 1'b0;
            analog_pins_o <= 16'h0000;
            sample_o <= 1'b0;
            calibrate_o <= 1'b0;
            led_o <= 2'h0;
        end else begin
            channel_select_o <= channel_select;
            neg_ref_select_o <= neg_ref_select;
            pos_ref_select_o <= pos_ref_select;
            // Pins absent from the package never report analog
            analog_pins_o <= analog_mask & present_mask;
            // Hold capacitor tracks input while enabled, unless calibrating or converting
            sample_o <= converter_on && (state == ST_IDLE || state == ST_ACQ ||
                        state == ST_GAP);
            calibrate_o <= converter_on && (state == ST_CAL);
            // LED drive passes regardless of pin configuration
            led_o <= led_i;
        end
    end

endmodule

`default_nettype wire

// file: pkg/adcc_consts.vh
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// Register byte offsets
`define ADCC_OFF_CTRL0 8'h00
`define ADCC_OFF_CTRL1 8'h04
`define ADCC_OFF_CTRL2 8'h08
`define ADCC_OFF_RESH 8'h0C
`define ADCC_OFF_RESL 8'h10
`define ADCC_OFF_ISTAT 8'h14
`define ADCC_OFF_ICLR 8'h18
`define ADCC_OFF_IEN 8'h1C

// Control register zero fields
`define ADCC_C0_CAL 7
`define ADCC_C0_CHS_HI 5
`define ADCC_C0_CHS_LO 2
`define ADCC_C0_GO 1
`define ADCC_C0_ON 0

// Control register one fields
`define ADCC_C1_NREF 5
`define ADCC_C1_PREF 4
`define ADCC_C1_PCFG_HI 3
`define ADCC_C1_PCFG_LO 0

// Control register two fields
`define ADCC_C2_FMT 7
`define ADCC_C2_ACQ_HI 5
`define ADCC_C2_ACQ_LO 3
`define ADCC_C2_CS_HI 2
`define ADCC_C2_CS_LO 0

// Reset value of control registers
`define ADCC_CTRL_RST 8'h00

// Interrupt bits
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_CAL 1

// Timing
`define ADCC_CLK_NS 100
`define ADCC_FRC_NS 1000
`define ADCC_FRC_CYC ((`ADCC_FRC_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_WAIT_TAD 5'h02
`define ADCC_CAL_TAD 5'h04

`endif

// file: testbench/adcc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] led_i,
    input wire logic [1:0] led_o,
    input wire logic [3:0] channel_select_o,
    input wire logic neg_ref_select_o,
    input wire logic pos_ref_select_o,
    input wire logic sample_o,
    input wire logic calibrate_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Committed writes to control registers zero and one
    wire wr_ctrl;
    assign wr_ctrl = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == 8'h00 || wb_adr_i == 8'h04);

    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_led;
        !$past(rst_i) |-> led_o == $past(led_i);
    endproperty
    property p_cfg;
        $changed({channel_select_o, neg_ref_select_o, pos_ref_select_o}) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
    endproperty
    property p_upper;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    property p_unimpl;
        wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o[7:6] == 2'b00;
    endproperty
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i > 8'h1C |-> wb_dat_o == 32'h00000000;
    endproperty
    property p_irq_rst;
        $past(rst_i) |-> !irq_o;
    endproperty
    property p_cal;
        calibrate_o |-> !sample_o;
    endproperty

    a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_led: assert property (p_led) else $error("led output not following input");
    a_cfg: assert property (p_cfg) else $error("control output changed without write");
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    a_unimpl: assert property (p_unimpl) else $error("unused control bits read set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_irq_rst: assert property (p_irq_rst) else $error("interrupt high after reset");
    a_cal: assert property (p_cal) else $error("sampling during calibration");

    // Main scenarios reached
    c_cal: cover property (calibrate_o);
    c_irq: cover property ($rose(irq_o));
    c_unmapped: cover property (wb_ack_o && wb_adr_i > 8'h1C);
endmodule
`default_nettype wire

// file: testbench/adcc_test.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic comp_i = 1'b0;
    logic [1:0] led_i = 2'b00;
    logic [31:0] rdat;
    logic ack, nref, pref, smp, cal, irq;
    logic [3:0] chs;
    logic [15:0] apins;
    logic [9:0] dac;
    logic [1:0] led_o;
    logic [9:0] vin = 10'h2A5;
    logic cal_seen = 1'b0;
    logic [31:0] rd;
    logic [15:0] m;
    logic [15:0] apins_s;
    integer fails = 0;
    integer n_checks = 0;
    integer k;

    adcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .comp_i(comp_i), .led_i(led_i),
        .channel_select_o(chs), .neg_ref_select_o(nref), .pos_ref_select_o(pref), .analog_pins_o(apins),
        .sample_o(smp), .calibrate_o(cal), .dac_o(dac), .led_o(led_o), .irq_o(irq));

    // Smallest package: inputs 5 and 12..15 not bonded out
    adcc_top #(.PKG_PINS(64)) uut_small (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
        .comp_i(comp_i), .led_i(led_i), .channel_select_o(), .neg_ref_select_o(), .pos_ref_select_o(),
        .analog_pins_o(apins_s), .sample_o(), .calibrate_o(), .dac_o(), .led_o(), .irq_o());

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // Comparator of the held input, moving led drive, calibration watch
    always @(posedge clk_i) begin
        comp_i <= (vin >= dac);
        led_i <= led_i + 2'b01;
        if (cal === 1'b1) cal_seen <= 1'b1;
    end

    task automatic give_verdict;
        begin
            $display("Comparisons %0d, mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        integer t;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            sel <= 4'hF;
            wdat <= {24'h000000, d};
            t = 0;
            do begin
                @(posedge clk_i);
                t = t + 1;
            end while (ack !== 1'b1 && t < 20);
            rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            if (ack !== 1'b1) begin
                fails = fails + 1;
                give_verdict();
            end
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        begin
            wb(1'b0, a, 8'h00);
            cmp(rd, e);
        end
    endtask

    task automatic wait_irq;
        integer t;
        begin
            t = 0;
            while (irq !== 1'b1 && t < 2000) begin
                @(posedge clk_i);
                t = t + 1;
            end
            if (irq !== 1'b1) begin
                fails = fails + 1;
                give_verdict();
            end
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(8'h00, 32'h00);
        rc(8'h04, 32'h00);
        cmp(apins, 32'hFFFF);
        cmp(apins_s, 32'h0FDF);
        $display("Test reset done");
        // Field placement and unused bits
        wb(1'b1, 8'h00, 8'hFC);
        rc(8'h00, 32'hBC);
        wb(1'b1, 8'h04, 8'hFF);
        rc(8'h04, 32'h3F);
        cmp({nref, pref}, 32'h3);
        wb(1'b1, 8'h04, 8'h10);
        repeat (2) @(posedge clk_i);
        cmp({nref, pref}, 32'h1);
        $display("Test fields done");
        // Every port code and channel code
        for (k = 0; k < 16; k = k + 1) begin
            wb(1'b1, 8'h04, k[7:0]);
            wb(1'b1, 8'h00, {2'b00, k[3:0], 2'b00});
            repeat (2) @(posedge clk_i);
            m = (k == 0) ? 16'hFFFF : (16'hFFFF >> (k + 1));
            cmp(apins, {16'h0000, m});
            cmp(apins_s, {16'h0000, m & 16'h0FDF});
            cmp(chs, k);
        end
        $display("Test codes done");
        // Start while disabled, unmapped place
        wb(1'b1, 8'h00, 8'h02);
        repeat (50) @(posedge clk_i);
        rc(8'h00, 32'h00);
        rc(8'h14, 32'h00);
        wb(1'b1, 8'h40, 8'h5A);
        rc(8'h40, 32'h00);
        $display("Test refused done");
        // Right justified conversion on channel 5
        wb(1'b1, 8'h1C, 8'h01);
        wb(1'b1, 8'h08, 8'h8A);
        wb(1'b1, 8'h00, 8'h15);
        wb(1'b1, 8'h00, 8'h17);
        rc(8'h00, 32'h17);
        cmp(smp, 32'h1);
        wait_irq;
        rc(8'h00, 32'h15);
        rc(8'h14, 32'h01);
        rc(8'h0C, 32'h02);
        rc(8'h10, 32'hA5);
        cmp(cal_seen, 32'h0);
        wb(1'b1, 8'h18, 8'h01);
        repeat (2) @(posedge clk_i);
        cmp(irq, 32'h0);
        $display("Test conversion done");
        // Left justified conversion with calibration
        wb(1'b1, 8'h08, 8'h05);
        wb(1'b1, 8'h00, 8'h97);
        wait_irq;
        rc(8'h0C, 32'hA9);
        rc(8'h10, 32'h40);
        rc(8'h14, 32'h03);
        cmp(cal_seen, 32'h1);
        rc(8'h00, 32'h95);
        wb(1'b1, 8'h1C, 8'h00);
        repeat (2) @(posedge clk_i);
        cmp(irq, 32'h0);
        wb(1'b1, 8'h1C, 8'h02);
        repeat (2) @(posedge clk_i);
        cmp(irq, 32'h1);
        wb(1'b1, 8'h18, 8'h03);
        rc(8'h14, 32'h00);
        $display("Test calibration done");
        // Abort by switching off
        wb(1'b1, 8'h00, 8'h17);
        wb(1'b1, 8'h00, 8'h00);
        repeat (600) @(posedge clk_i);
        rc(8'h14, 32'h00);
        rc(8'h0C, 32'hA9);
        cmp(smp, 32'h0);
        // Reset in mid conversion, module switched on first
        wb(1'b1, 8'h00, 8'h15);
        wb(1'b1, 8'h00, 8'h17);
        rc(8'h00, 32'h17);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (600) @(posedge clk_i);
        rc(8'h00, 32'h00);
        rc(8'h14, 32'h00);
        rc(8'h0C, 32'hA9);
        $display("Test abort done");
        give_verdict();
    end
endmodule

bind adcc_top adcc_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .led_i(led_i),
    .led_o(led_o), .channel_select_o(channel_select_o), .neg_ref_select_o(neg_ref_select_o),
    .pos_ref_select_o(pos_ref_select_o), .sample_o(sample_o), .calibrate_o(calibrate_o), .irq_o(irq_o));
`default_nettype wire
